// [design/ifds_status.sv]
// The APB interface to the registers and the register offsets were chosen for this implementation.
module ifds_status
  import ifds_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire ifds_meas_t  meas,
  input  wire logic        overcurrent_detect,
  input  wire logic        overtemp_detect,
  output logic             irq_request,
  output ifds_pd_t         powerdown
);

  // absolute difference of two measurements
  function automatic logic [MW-1:0] abs_diff(input logic [MW-1:0] a, input logic [MW-1:0] b);
    abs_diff = (a >= b) ? (a - b) : (b - a);
  endfunction

  // a 4-bit threshold spans the top nibble of the measurement scale
  function automatic logic [MW-1:0] scale_thr(input logic [3:0] t);
    scale_thr = {t, 4'h0};
  endfunction

  // bits a read may clear: only bits actually reported, and under policy 1
  // only those whose live bit is low at the read
  function automatic logic [LW-1:0] clr_mask(input logic hit, input logic [LW-1:0] shown,
                                             input logic [LW-1:0] live, input logic policy);
    if (!hit)
      clr_mask = '0;
    else if (policy)
      clr_mask = shown & ~live;
    else
      clr_mask = shown;
  endfunction

  logic [7:0]  cfg;
  logic [15:0] thr;
  logic [LW-1:0] live      [NCH];
  logic [LW-1:0] ltch      [NCH];
  logic [SW-1:0] summ      [NCH];
  logic [LW-1:0] raw       [NCH];
  logic [LW-1:0] set_ev    [NCH];
  logic [SW-1:0] summ_live [NCH];
  logic [SW-1:0] summ_set  [NCH];
  logic [NCH-1:0] ch_rise;
  logic [7:0]  glive;
  logic [7:0]  gltch;
  logic [7:0]  gprev;
  logic [7:0]  gset;
  logic [7:0]  gclr;
  logic        setup;
  logic        access;
  logic        rd_access;
  logic        wr_access;
  logic        addr_hit;
  logic [31:0] rd_mux;
  logic        policy;
  logic [3:0]  norm_target;
  logic        bat_low;

  assign policy    = cfg[CFG_POLICY_BIT];
  assign setup     = psel & ~penable;
  assign access    = psel & penable & pready;
  assign rd_access = access & ~pwrite;
  assign wr_access = access & pwrite;

  // persistence target 1..4 scans, battery case may stretch to 8
  assign norm_target = {2'b00, cfg[CFG_DBNC_LSB +: 2]} + 4'h1;
  assign bat_low     = meas.battery < meas.bias;

  // global live flags; overtemp detector gated by its enable
  always_comb
  begin
    glive       = '0;
    glive[G_OC] = overcurrent_detect;
    glive[G_OT] = overtemp_detect & cfg[CFG_OTEN_BIT];
  end

  assign gset = glive & ~gprev;
  assign gclr = clr_mask(rd_access && (paddr == GLOBAL_LTCH_OFS), prdata[7:0], glive, policy);

  genvar c;
  generate
    for (c = 0; c < NCH; c++)
    begin : g_ch
      logic [3:0] cnt [LW];
      logic [MW-1:0] p;
      logic [MW-1:0] m;
      logic p_bat;
      logic m_bat;
      logic [LW-1:0] clr;
      logic [SW-1:0] sclr;
      logic [11:0] ltch_addr;
      logic [11:0] summ_addr;

      assign p = meas.pos[c];
      assign m = meas.neg[c];
      assign ltch_addr = LTCH_BASE + CH_STRIDE * 12'(c);
      assign summ_addr = SUMM_BASE + CH_STRIDE * 12'(c);

      // battery short on either pin, absolute band or both high
      assign p_bat = (abs_diff(meas.battery, p) < scale_thr(thr[THR_BAT_LSB +: 4])) ||
                     ((meas.battery > BAT_HIGH_CODE) && (p > BAT_HIGH_CODE));
      assign m_bat = (abs_diff(meas.battery, m) < scale_thr(thr[THR_BAT_LSB +: 4])) ||
                     ((meas.battery > BAT_HIGH_CODE) && (m > BAT_HIGH_CODE));

      // raw classification of this scan
      always_comb
      begin
        raw[c] = '0;
        raw[c][F_TERM]  = abs_diff(p, m) < scale_thr(thr[THR_TERM_LSB +: 4]);
        raw[c][F_PGND]  = p < scale_thr(thr[THR_GND_LSB +: 4]);
        raw[c][F_MGND]  = m < scale_thr(thr[THR_GND_LSB +: 4]);
        // pin at or above bias gives a non-positive difference
        raw[c][F_PBIAS] = (p >= meas.bias) ||
                          ((meas.bias - p) < scale_thr(thr[THR_BIAS_LSB +: 4]));
        raw[c][F_MBIAS] = (m >= meas.bias) ||
                          ((meas.bias - m) < scale_thr(thr[THR_BIAS_LSB +: 4]));
        raw[c][F_OV]    = (p > meas.bias) || (m > meas.bias);
        raw[c][F_BAT]   = p_bat | m_bat;
        raw[c][F_OPEN]  = raw[c][F_PBIAS] & raw[c][F_MGND];
      end

      // live bits follow each completed scan
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          live[c] <= '0;
        else if (meas.valid)
          live[c] <= raw[c];
      end

      // per-bit persistence counters, saturating at their target
      for (genvar b = 0; b < LW; b++)
      begin : g_bit
        logic [3:0] target;
        assign target = (b == F_BAT && cfg[CFG_BATDB_BIT] && bat_low) ?
                        BAT_DEBOUNCE_SCANS : norm_target;
        assign set_ev[c][b] = meas.valid & raw[c][b] & ((cnt[b] + 4'h1) == target);

        always_ff @(posedge pclk or negedge presetn)
        begin
          if (!presetn)
            cnt[b] <= '0;
          else if (meas.valid)
          begin
            if (!raw[c][b])
              cnt[b] <= '0;
            else if (cnt[b] < target)
              cnt[b] <= cnt[b] + 4'h1;
          end
        end
      end

      // summary groups: open, any short, overvoltage, battery
      assign summ_live[c] = {live[c][F_BAT], live[c][F_OV],
                             |{live[c][F_TERM], live[c][F_PGND], live[c][F_PBIAS],
                               live[c][F_MGND], live[c][F_MBIAS]},
                             live[c][F_OPEN]};
      assign summ_set[c]  = {set_ev[c][F_BAT], set_ev[c][F_OV],
                             |{set_ev[c][F_TERM], set_ev[c][F_PGND], set_ev[c][F_PBIAS],
                               set_ev[c][F_MGND], set_ev[c][F_MBIAS]},
                             set_ev[c][F_OPEN]};

      assign clr  = clr_mask(rd_access && (paddr == ltch_addr), prdata[LW-1:0],
                             live[c], policy);
      assign sclr = SW'(clr_mask(rd_access && (paddr == summ_addr), LW'(prdata[SW-1:0]),
                                 LW'(summ_live[c]), policy));

      // latched faults and summary; a set in the read cycle survives the clear
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          ltch[c] <= '0;
          summ[c] <= '0;
        end
        else
        begin
          ltch[c] <= (ltch[c] & ~clr) | set_ev[c];
          summ[c] <= (summ[c] & ~sclr) | summ_set[c];
        end
      end

      assign ch_rise[c] = |(set_ev[c] & ~ltch[c]) | |(summ_set[c] & ~summ[c]);
    end
  endgenerate

  // global latched flags set on rise of their live bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gprev <= '0;
      gltch <= '0;
    end
    else
    begin
      gprev <= glive;
      gltch <= (gltch & ~gclr) | gset;
    end
  end

  // one-cycle request when any latched bit is fresh; bits that set in the same cycle share one request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_request <= 1'b0;
    else
      irq_request <= (|ch_rise) | (|(gset & ~gltch));
  end

  // fault power-down follows the live overtemperature flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      powerdown <= '0;
    else
    begin
      powerdown.bias  <= glive[G_OT] && (cfg[CFG_PDSEL_LSB +: 2] != PD_NONE);
      powerdown.boost <= glive[G_OT] && (cfg[CFG_PDSEL_LSB +: 2] != PD_NONE);
      powerdown.adc   <= glive[G_OT] && (cfg[CFG_PDSEL_LSB +: 2] != PD_NONE) &&
                         (cfg[CFG_PDSEL_LSB +: 2] != PD_BIAS);
    end
  end

  // read decode, evaluated in the setup cycle
  always_comb
  begin
    rd_mux   = '0;
    addr_hit = 1'b1;
    case (paddr)
      CFG_OFS:         rd_mux = {24'h000000, cfg};
      THR_OFS:         rd_mux = {16'h0000, thr};
      GLOBAL_LIVE_OFS: rd_mux = {24'h000000, glive};
      GLOBAL_LTCH_OFS: rd_mux = {24'h000000, gltch};
      default:
      begin
        addr_hit = 1'b0;
        for (int i = 0; i < NCH; i++)
        begin
          if (paddr == LIVE_BASE + CH_STRIDE * 12'(i))
          begin
            rd_mux   = {24'h000000, live[i]};
            addr_hit = 1'b1;
          end
          if (paddr == LTCH_BASE + CH_STRIDE * 12'(i))
          begin
            rd_mux   = {24'h000000, ltch[i]};
            addr_hit = 1'b1;
          end
          if (paddr == SUMM_BASE + CH_STRIDE * 12'(i))
          begin
            rd_mux   = {28'h0000000, summ[i]};
            addr_hit = 1'b1;
          end
        end
      end
    endcase
  end

  // wait-free answer: data captured at setup so the clear sees what was shown
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~addr_hit;
      if (setup && !pwrite)
        prdata <= addr_hit ? rd_mux : 32'h00000000;
    end
  end

  // software configuration writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg <= CFG_RESET; // policy 1 and overtemp enable after reset
      thr <= THR_RESET;
    end
    else if (wr_access)
    begin
      if (paddr == CFG_OFS && pstrb[0])
        cfg <= pwdata[7:0] & 8'h7F;
      if (paddr == THR_OFS && pstrb[0])
        thr[7:0] <= pwdata[7:0];
      if (paddr == THR_OFS && pstrb[1])
        thr[15:8] <= pwdata[15:8];
    end
  end

endmodule

// [pkg/ifds_pkg.sv]
package ifds_pkg;

  // geometry of the diagnostic measurement path
  localparam int NCH = 2;
  localparam int MW  = 8;
  localparam int LW  = 8;
  localparam int SW  = 4;

  // one completed scan from the sequencing converter
  typedef struct packed {
    logic                   valid;
    logic [NCH-1:0][MW-1:0] pos;
    logic [NCH-1:0][MW-1:0] neg;
    logic [MW-1:0]          bias;
    logic [MW-1:0]          battery;
  } ifds_meas_t;

  // requests to the analog power control
  typedef struct packed {
    logic bias;
    logic boost;
    logic adc;
  } ifds_pd_t;

  // register byte offsets
  localparam logic [11:0] CFG_OFS         = 12'h000;
  localparam logic [11:0] THR_OFS         = 12'h004;
  localparam logic [11:0] GLOBAL_LIVE_OFS = 12'h008;
  localparam logic [11:0] GLOBAL_LTCH_OFS = 12'h00C;
  localparam logic [11:0] LIVE_BASE       = 12'h010;
  localparam logic [11:0] LTCH_BASE       = 12'h020;
  localparam logic [11:0] SUMM_BASE       = 12'h030;
  localparam logic [11:0] CH_STRIDE       = 12'h004;

  // configuration fields
  localparam int CFG_POLICY_BIT  = 0;
  localparam int CFG_DBNC_LSB    = 1;
  localparam int CFG_BATDB_BIT   = 3;
  localparam int CFG_PDSEL_LSB   = 4;
  localparam int CFG_OTEN_BIT    = 6;
  localparam logic [7:0] CFG_RESET = 8'h41;

  // threshold fields
  localparam int THR_BAT_LSB  = 0;
  localparam int THR_TERM_LSB = 4;
  localparam int THR_BIAS_LSB = 8;
  localparam int THR_GND_LSB  = 12;
  localparam logic [15:0] THR_RESET = 16'h0000;

  // per-channel fault bit positions
  localparam int F_OPEN = 0;
  localparam int F_TERM = 1;
  localparam int F_PGND = 2;
  localparam int F_PBIAS = 3;
  localparam int F_MGND = 4;
  localparam int F_MBIAS = 5;
  localparam int F_OV   = 6;
  localparam int F_BAT  = 7;

  // global status bit positions
  localparam int G_OC = 2;
  localparam int G_OT = 5;

  // debounce and level constants
  localparam logic [3:0] BAT_DEBOUNCE_SCANS = 4'h8;
  localparam int BAT_HIGH_MV = 11700;
  localparam int MEAS_LSB_MV = 50;
  localparam logic [MW-1:0] BAT_HIGH_CODE = MW'(BAT_HIGH_MV / MEAS_LSB_MV);

  // power-down select codes
  localparam logic [1:0] PD_NONE = 2'h0;
  localparam logic [1:0] PD_BIAS = 2'h1;

endpackage

// [verification/ifds_scan_src.sv]
module ifds_scan_src
  import ifds_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       fire,
  input wire ifds_meas_t next_meas,
  output ifds_meas_t     meas
);
  timeunit 1ns;
  timeprecision 1ps;

  // one-cycle scan; idle lines toggle so stale codes never look valid
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      meas <= '0;
    else if (fire)
      meas <= {1'b1, next_meas[$bits(ifds_meas_t)-2:0]};
    else
      meas <= {1'b0, ~meas[$bits(ifds_meas_t)-2:0]};
  end
endmodule

// [verification/ifds_status_sva.sv]
module ifds_status_sva
  import ifds_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire ifds_meas_t  meas,
  input wire logic        overcurrent_detect,
  input wire logic        overtemp_detect,
  input wire logic        irq_request,
  input wire ifds_pd_t    powerdown
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // bus timing: one wait-free access per setup
  AST_READY_NEXT: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_CFG_MAPPED: assert property (psel && penable && paddr == CFG_OFS |-> !pslverr)
    else $error("error on mapped address");
  AST_RD_STABLE: assert property (psel && penable && pready && !pwrite |=> $stable(prdata))
    else $error("read data moved after access");
  AST_HI_ZERO: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  // with no scan and no protection flag there is nothing new, so the request drops
  AST_IRQ_PULSE: assert property (irq_request && !meas.valid && !overcurrent_detect &&
    !overtemp_detect |=> !irq_request)
    else $error("irq longer than a cycle");
  // adc shutdown never without bias and boost
  AST_PD_ORDER: assert property (powerdown.adc |-> powerdown.bias && powerdown.boost)
    else $error("adc down alone");
  AST_PD_IDLE: assert property (!overtemp_detect [*3] |-> powerdown == 3'h0)
    else $error("powerdown without overtemp");
endmodule

// [verification/tb.sv]
`define CHK(a, b) n_checks++; if ((a) !== (b)) begin errors++; $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end
module tb
  import ifds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk, presetn, psel, penable, pwrite, fire, overcurrent_detect, overtemp_detect;
  logic        pready, pslverr, irq_request, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  ifds_meas_t  meas, next_meas;
  ifds_pd_t    powerdown;
  int          errors = 0, n_checks = 0, irqs = 0;

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  ifds_status dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas(meas), .overcurrent_detect(overcurrent_detect),
    .overtemp_detect(overtemp_detect), .irq_request(irq_request), .powerdown(powerdown));
  ifds_scan_src src_u (.pclk(pclk), .presetn(presetn), .fire(fire), .next_meas(next_meas),
    .meas(meas));

  // count interrupt pulses
  always @(posedge pclk)
    if (irq_request === 1'b1)
      irqs <= irqs + 1;

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // apb transfer: request held until pready seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: a slave that never answers is caught by the hang guard
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  // channel 1 sits in a fault-free spot except a battery short when ba nears its 8'h60 plus or 8'h20 minus pin
  task automatic scan(input logic [7:0] p0, input logic [7:0] n0, input logic [7:0] ba);
    @(posedge pclk);
    fire <= 1'b1;
    next_meas <= {1'b0, 8'h60, p0, 8'h20, n0, 8'h80, ba};
    @(posedge pclk);
    fire <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  initial
  begin
    {presetn, psel, penable, pwrite, fire, overcurrent_detect, overtemp_detect} = 7'h0;
    {paddr, pwdata, next_meas} = '0;
    pstrb = 4'hF;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(CFG_OFS, 32'h41);
    rdc(THR_OFS, 32'h0);
    rdc(12'h0FC, 32'h0);
    `CHK(er, 1'b1)
    // only byte lane 1 may land
    pstrb <= 4'h2;
    xfer(1'b1, THR_OFS, 32'hFFFF);
    pstrb <= 4'hF;
    rdc(THR_OFS, 32'hFF00);
    $display("reset test done");
    // battery threshold zero: only the high-level branch can flag
    xfer(1'b1, THR_OFS, 32'h2230);
    xfer(1'b1, CFG_OFS, 32'h40);
    scan(8'h10, 8'h10, 8'h00);
    rdc(LIVE_BASE, 32'h16);
    `CHK(irqs, 1)
    rdc(SUMM_BASE, 32'h02);
    rdc(LTCH_BASE, 32'h16);
    rdc(LTCH_BASE, 32'h00);
    $display("clear-any test done");
    xfer(1'b1, CFG_OFS, 32'h43);
    scan(8'h78, 8'h10, 8'h00);
    rdc(LTCH_BASE, 32'h10);
    scan(8'h78, 8'h10, 8'h00);
    rdc(LTCH_BASE, 32'h19);
    rdc(LTCH_BASE, 32'h19);
    scan(8'h60, 8'h20, 8'h00);
    rdc(LIVE_BASE, 32'h00);
    rdc(LTCH_BASE, 32'h19);
    rdc(LTCH_BASE, 32'h00);
    `CHK(irqs, 3)
    $display("persistent test done");
    // battery below bias stretches the battery persistence to its own count
    xfer(1'b1, THR_OFS, 32'h2231);
    xfer(1'b1, CFG_OFS, 32'h49);
    scan(8'h60, 8'h20, 8'h60);
    rdc(LIVE_BASE, 32'h80);
    rdc(LTCH_BASE, 32'h00);
    repeat (7) scan(8'h60, 8'h20, 8'h60);
    rdc(LTCH_BASE, 32'h80);
    xfer(1'b1, THR_OFS, 32'h2230);
    $display("battery debounce test done");
    for (int b = 8'hEA; b <= 8'hEB; b++)
    begin
      scan(8'(b), 8'(b), 8'(b));
      rdc(LIVE_BASE, {24'h0, b[0], 7'h6A});
    end
    $display("level test done");
    overcurrent_detect <= 1'b1;
    repeat (4) @(posedge pclk);
    rdc(GLOBAL_LIVE_OFS, 32'h04);
    overcurrent_detect <= 1'b0;
    xfer(1'b1, CFG_OFS, 32'h63);
    overtemp_detect <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK(powerdown, 3'b111)
    rdc(GLOBAL_LIVE_OFS, 32'h20);
    rdc(GLOBAL_LTCH_OFS, 32'h24);
    rdc(GLOBAL_LTCH_OFS, 32'h20);
    xfer(1'b1, CFG_OFS, 32'h53);
    repeat (4) @(posedge pclk);
    `CHK(powerdown, 3'b110)
    xfer(1'b1, CFG_OFS, 32'h03);
    repeat (4) @(posedge pclk);
    rdc(GLOBAL_LIVE_OFS, 32'h00);
    `CHK(powerdown, 3'b000)
    overtemp_detect <= 1'b0;
    $display("protection test done");
    conclude();
  end

  // hang guard
  initial
  begin
    #20000;
    errors++;
    conclude();
  end
endmodule

bind ifds_status ifds_status_sva sva_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas(meas),
  .overcurrent_detect(overcurrent_detect), .overtemp_detect(overtemp_detect),
  .irq_request(irq_request), .powerdown(powerdown));
